/* design/interval_timer.sv */
`default_nettype none
`include "lpcal_consts.svh"

module interval_timer
  import lpcal_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire logic [`LPC_CNT_W-1:0] length_in,
  output logic busy_out,
  output logic done_out
);

  timer_state_t r_q;
  timer_state_t r_d;

  // ----------------------------------------------------------------
  // Down counter, reloaded on every start
  // ----------------------------------------------------------------
  always_comb
  begin
    r_d = r_q;
    if (start_in)
    begin
      r_d.running = 1'b1;
      r_d.count = length_in - `LPC_CNT_W'(1);
    end
    else if (r_q.running)
    begin
      if (r_q.count == '0)
        r_d.running = 1'b0;
      else
        r_d.count = r_q.count - `LPC_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      r_q <= '0;
    else
      r_q <= r_d;
  end

  assign busy_out = r_q.running;
  assign done_out = r_q.running && (r_q.count == '0);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_timer_reload: assert property (@(posedge clk_in) disable iff (!rstn_in)
    start_in |=> r_q.running && (r_q.count == $past(length_in) - `LPC_CNT_W'(1)))
    else $error("timer not reloaded on start");

endmodule : interval_timer

`default_nettype wire

/* design/lowpower_bg_cal_scheduler.sv */
// Added by the designer: register access over Wishbone and the register addresses.
`default_nettype none
`include "lpcal_consts.svh"

module lowpower_bg_cal_scheduler
  import lpcal_pkg::*;
#(
  parameter logic [`LPC_CNT_W-1:0] UNIT_CYCLES = `LPC_UNIT_CYCLES,
  parameter logic [8*`LPC_K_W-1:0] NAP_K_LIST = `LPC_NAP_K_LIST,
  parameter logic [4*`LPC_K_W-1:0] WAKE_K_LIST = `LPC_WAKE_K_LIST
)
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [`LPC_ADR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic cal_trigger_pin_in,
  input wire logic cal_done_in,
  output logic core_sleep_out,
  output logic core_settle_out,
  output logic cal_request_out
);

  sched_state_t r_q;
  sched_state_t r_d;
  logic req;
  logic active;
  logic trig_mode;
  logic cal_trig;
  logic tstart;
  logic [`LPC_CNT_W-1:0] tlen;
  logic tbusy;
  logic tdone;
  logic [`LPC_CNT_W-1:0] nap_len;
  logic [`LPC_CNT_W-1:0] wake_len;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [`LPC_CNT_W-1:0] interval_len(
    input logic [`LPC_K_W-1:0] k,
    input logic [`LPC_CNT_W-1:0] unit
  );
    logic [`LPC_CNT_W-1:0] one;
    one = `LPC_CNT_W'(1);
    return `LPC_CNT_W'(((one << k) + one) * unit);
  endfunction : interval_len

  function automatic logic addr_hit(
    input logic [`LPC_ADR_W-1:0] adr,
    input logic [`LPC_ADR_W-1:0] off
  );
    return adr == off;
  endfunction : addr_hit

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  assign req = wb_cyc_in && wb_stb_in;
  assign active = r_q.ctrl[`LPC_EN_BIT] && r_q.trig[`LPC_BGEN_BIT];
  assign trig_mode = r_q.ctrl[`LPC_TMODE_BIT];
  // Pin only counts once filtered; the software bit is already local
  assign cal_trig = r_q.trig[`LPC_SRC_BIT] ? r_q.pin_filt : r_q.trig[`LPC_SWTRIG_BIT];
  assign nap_len = interval_len(
    NAP_K_LIST[r_q.ctrl[`LPC_NAP_HI:`LPC_NAP_LO]*`LPC_K_W +: `LPC_K_W], UNIT_CYCLES);
  assign wake_len = interval_len(
    WAKE_K_LIST[r_q.ctrl[`LPC_WAKE_HI:`LPC_WAKE_LO]*`LPC_K_W +: `LPC_K_W], UNIT_CYCLES);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    r_d = r_q;
    tstart = 1'b0;
    tlen = nap_len;

    r_d.sync = {r_q.sync[1], r_q.sync[0], cal_trigger_pin_in};
    if (r_q.sync[2] == r_q.sync[1])
      r_d.pin_filt = r_q.sync[2];

    r_d.ack = req && !r_q.ack;
    if (req && !r_q.ack)
    begin
      r_d.rdat = '0;
      if (addr_hit(wb_adr_in, `LPC_ADDR_CTRL))
        r_d.rdat[7:0] = r_q.ctrl;
      else if (addr_hit(wb_adr_in, `LPC_ADDR_TRIG))
        r_d.rdat[2:0] = r_q.trig;
      else if (addr_hit(wb_adr_in, `LPC_ADDR_STAT))
        r_d.rdat[2:0] = {cal_trig, r_q.st};
    end
    if (req && r_q.ack && wb_we_in && wb_sel_in[0])
    begin
      if (addr_hit(wb_adr_in, `LPC_ADDR_CTRL))
        r_d.ctrl = wb_dat_in[7:0];
      else if (addr_hit(wb_adr_in, `LPC_ADDR_TRIG))
        r_d.trig = wb_dat_in[2:0];
    end

    case (r_q.st)
      ST_IDLE:
      begin
        if (active)
        begin
          r_d.st = ST_NAP;
          tstart = !trig_mode;
        end
      end
      ST_NAP:
      begin
        if (!active)
          r_d.st = ST_IDLE;
        else if (trig_mode)
        begin
          if (!cal_trig)
          begin
            r_d.st = ST_SETTLE;
            tstart = 1'b1;
            tlen = wake_len;
          end
        end
        else if (tdone)
        begin
          r_d.st = ST_SETTLE;
          tstart = 1'b1;
          tlen = wake_len;
        end
        else if (!tbusy)
          tstart = 1'b1;
      end
      ST_SETTLE:
      begin
        if (!active)
          r_d.st = ST_IDLE;
        else if (tdone)
          r_d.st = ST_CAL;
      end
      ST_CAL:
      begin
        if (!active)
          r_d.st = ST_IDLE;
        else if (cal_done_in)
        begin
          r_d.st = ST_NAP;
          tstart = !trig_mode;
        end
      end
      default:
        r_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      r_q <= '0;
      r_q.st <= ST_IDLE;
      r_q.ctrl <= `LPC_CTRL_RST;
      r_q.trig <= `LPC_TRIG_RST;
      r_q.sync <= `LPC_SYNC_RST;
      r_q.pin_filt <= 1'b1;
    end
    else
      r_q <= r_d;
  end

  interval_timer u_timer (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .start_in(tstart),
    .length_in(tlen),
    .busy_out(tbusy),
    .done_out(tdone)
  );

  assign wb_dat_out = r_q.rdat;
  assign wb_ack_out = r_q.ack;
  assign core_sleep_out = (r_q.st == ST_NAP);
  assign core_settle_out = (r_q.st == ST_SETTLE);
  assign cal_request_out = (r_q.st == ST_CAL);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic seen_q;
  logic [`LPC_CNT_W-1:0] cnt_q;
  logic [`LPC_CNT_W-1:0] len_q;

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      seen_q <= 1'b0;
      cnt_q <= '0;
      len_q <= '0;
    end
    else
    begin
      seen_q <= 1'b1;
      if (tstart)
      begin
        cnt_q <= '0;
        len_q <= tlen;
      end
      else
        cnt_q <= cnt_q + `LPC_CNT_W'(1);
    end
  end

  a_reset_disabled: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !seen_q |-> !r_q.ctrl[`LPC_EN_BIT] && (r_q.ctrl == `LPC_CTRL_RST))
    else $error("control register not at reset value");

  a_off_goes_idle: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !active |=> r_q.st == ST_IDLE)
    else $error("scheduler running while disabled");

  a_nap_length: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (r_q.st == ST_NAP) && !trig_mode && tdone |-> (cnt_q + `LPC_CNT_W'(1) == len_q))
    else $error("sleep interval length wrong");

  a_settle_length: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (r_q.st == ST_SETTLE) && tdone |-> (cnt_q + `LPC_CNT_W'(1) == len_q))
    else $error("settle interval length wrong");

  a_nap_code: assert property (@(posedge clk_in) disable iff (!rstn_in)
    tstart && (r_d.st == ST_NAP) |=> tbusy && (len_q == $past(nap_len)))
    else $error("sleep length not taken from code");

  a_trig_holds: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (r_q.st == ST_NAP) && trig_mode && cal_trig && active |=> r_q.st == ST_NAP)
    else $error("woke without trigger low");

  a_trig_wakes: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (r_q.st == ST_NAP) && trig_mode && !cal_trig && active |=> r_q.st == ST_SETTLE ##1 tbusy)
    else $error("trigger low did not wake core");

  a_source_pick: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !r_q.trig[`LPC_SRC_BIT] && $stable(r_q.trig) |-> cal_trig == r_q.trig[`LPC_SWTRIG_BIT])
    else $error("pin used while software source selected");

  // Trigger mode has no sleep count, so only auto mode must restart it
  a_cal_to_nap: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (r_q.st == ST_CAL) && cal_done_in && active
    |=> (r_q.st == ST_NAP) && ($past(trig_mode) || cnt_q == '0))
    else $error("calibration end did not restart sleep");

  a_ctrl_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
    req && r_q.ack && wb_we_in && wb_sel_in[0] && addr_hit(wb_adr_in, `LPC_ADDR_CTRL)
    |=> r_q.ctrl == $past(wb_dat_in[7:0]) ##1 !wb_ack_out)
    else $error("control write lost");

  a_settle_code: assert property (@(posedge clk_in) disable iff (!rstn_in)
    tstart && (r_d.st == ST_SETTLE) |=> tbusy && (len_q == $past(wake_len)))
    else $error("settle length not taken from code");

  a_trig_no_count: assert property (@(posedge clk_in) disable iff (!rstn_in)
    tstart && (r_d.st == ST_NAP) |-> !trig_mode)
    else $error("sleep count started in trigger mode");

  a_pin_filter: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (r_q.sync[2] != r_q.sync[1]) |=> $stable(r_q.pin_filt))
    else $error("pin taken before two stages agree");

  a_cal_holds: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (r_q.st == ST_CAL) && active && !cal_done_in |=> cal_request_out)
    else $error("calibration request dropped early");

  a_ack_answer: assert property (@(posedge clk_in) disable iff (!rstn_in)
    req && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
    else $error("bus answer not a single pulse");

  c_auto_wake: cover property (@(posedge clk_in) disable iff (!rstn_in)
    (r_q.st == ST_NAP) && !trig_mode ##1 r_q.st == ST_SETTLE);
  c_trig_wake: cover property (@(posedge clk_in) disable iff (!rstn_in)
    (r_q.st == ST_NAP) && trig_mode ##1 r_q.st == ST_SETTLE);
  c_cal_done: cover property (@(posedge clk_in) disable iff (!rstn_in)
    (r_q.st == ST_CAL) ##1 r_q.st == ST_NAP);
  c_bus_read: cover property (@(posedge clk_in) disable iff (!rstn_in)
    wb_ack_out && !wb_we_in && addr_hit(wb_adr_in, `LPC_ADDR_STAT));

endmodule : lowpower_bg_cal_scheduler

`default_nettype wire

/* design/lpcal_consts.svh */
`ifndef LPCAL_CONSTS_SVH
`define LPCAL_CONSTS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define LPC_ADR_W 8
`define LPC_ADDR_CTRL 8'h00
`define LPC_ADDR_TRIG 8'h04
`define LPC_ADDR_STAT 8'h08

// ----------------------------------------------------------------
// Control register fields and reset
// ----------------------------------------------------------------
`define LPC_CTRL_RST 8'h88
`define LPC_EN_BIT 0
`define LPC_TMODE_BIT 1
`define LPC_NAP_HI 7
`define LPC_NAP_LO 5
`define LPC_WAKE_HI 4
`define LPC_WAKE_LO 3

// ----------------------------------------------------------------
// Trigger register fields and reset
// ----------------------------------------------------------------
`define LPC_TRIG_RST 3'h1
`define LPC_SWTRIG_BIT 0
`define LPC_SRC_BIT 1
`define LPC_BGEN_BIT 2

// ----------------------------------------------------------------
// Interval timing
// ----------------------------------------------------------------
`define LPC_CNT_W 48
`define LPC_K_W 6
`define LPC_UNIT_CYCLES 48'h0000_0000_0100
`define LPC_NAP_K_LIST {6'h21, 6'h1E, 6'h1B, 6'h18, 6'h15, 6'h12, 6'h0F, 6'h03}
`define LPC_WAKE_K_LIST {6'h18, 6'h15, 6'h12, 6'h03}
`define LPC_SYNC_RST 3'h7

`endif

/* design/lpcal_pkg.sv */
`default_nettype none
`include "lpcal_consts.svh"

package lpcal_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_NAP, ST_SETTLE, ST_CAL} phase_t;

  typedef struct packed {
    logic running;
    logic [`LPC_CNT_W-1:0] count;
  } timer_state_t;

  typedef struct packed {
    phase_t st;
    logic [7:0] ctrl;
    logic [2:0] trig;
    logic ack;
    logic [31:0] rdat;
    logic [2:0] sync;
    logic pin_filt;
  } sched_state_t;

endpackage : lpcal_pkg

`default_nettype wire

/* verif/cal_partner.sv */
`default_nettype none

module cal_partner
(
  input wire logic clk_in,
  input wire logic cal_request_in,
  input wire logic wake_in,
  output logic cal_done_out = 1'b0,
  output logic cal_trigger_pin_out = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned dly = 0;

  // ------
  // Engine and trigger source
  // ------
  // Random finish delay from the second request on, so done moves about; the first finishes at once
  always @(posedge clk_in)
  begin
    cal_done_out <= 1'b0;
    cal_trigger_pin_out <= ~wake_in;
    if (cal_request_in && !cal_done_out)
    begin
      if (dly == 0)
      begin
        cal_done_out <= 1'b1;
        dly = $urandom_range(4, 0);
      end
      else
        dly = dly - 1;
    end
  end
endmodule : cal_partner

`default_nettype wire

/* verif/lowpower_bg_cal_scheduler_test.sv */
`default_nettype none
`include "lpcal_consts.svh"

module lowpower_bg_cal_scheduler_test import lpcal_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in, rstn_in, cyc, stb, we, ack, pin, done, slp, stl, req, wake;
  logic [7:0] adr;
  logic [31:0] wdat, rdat;
  logic [31:0] expq[$];
  logic [7:0] v;
  int err_total, total_checks, n, c;

  lowpower_bg_cal_scheduler #(
    .UNIT_CYCLES(48'h1),
    .NAP_K_LIST({6'h07, 6'h06, 6'h05, 6'h04, 6'h03, 6'h02, 6'h01, 6'h00}),
    .WAKE_K_LIST({6'h03, 6'h02, 6'h01, 6'h00})
  ) dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .cal_trigger_pin_in(pin), .cal_done_in(done),
    .core_sleep_out(slp), .core_settle_out(stl), .cal_request_out(req));

  cal_partner far_u (.clk_in(clk_in), .cal_request_in(req), .wake_in(wake),
    .cal_done_out(done), .cal_trigger_pin_out(pin));

  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // ------
  // Checks and bus
  // ------
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s exp %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  // For reads d is the expected word
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= w ? d : 32'h0;
    if (!w)
      expq.push_back(d);
    for (i = 0; i < 20 && ack !== 1'b1; i++)
      @(posedge clk_in);
    if (i == 20)
    begin
      err_total++;
      results();
    end
    else
    begin
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask : bus

  always @(posedge clk_in)
  begin
    if (ack === 1'b1 && cyc && !we)
    begin
      if (expq.size() == 0)
        chk("unexpected read", 1, 0);
      else
        chk("rdata", rdat, expq.pop_front());
    end
  end

  function logic ph(input int s);
    return s == 0 ? slp : (s == 1 ? stl : req);
  endfunction : ph

  // Counts cycles of one phase; bounded so a phase that never starts ends the run
  task span(input int s, output int k);
    int i;
    k = 0;
    for (i = 0; i < 400 && ph(s) !== 1'b1; i++)
    begin
      @(posedge clk_in);
      #1;
    end
    while (ph(s) === 1'b1 && k < 400)
    begin
      k++;
      @(posedge clk_in);
      #1;
    end
    if (i == 400)
    begin
      err_total++;
      results();
    end
  endtask : span

  // ------
  // Main sequence
  // ------
  initial
  begin
    cyc = 0;
    stb = 0;
    we = 0;
    adr = 0;
    wdat = 0;
    wake = 0;
    rstn_in = 0;
    err_total = 0;
    total_checks = 0;
    void'($urandom(18));
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'b1;
    bus(0, `LPC_ADDR_CTRL, 32'h88);
    bus(0, `LPC_ADDR_TRIG, 32'h1);
    bus(0, 8'h0C, 32'h0);
    bus(1, `LPC_ADDR_CTRL, 32'h89);
    bus(0, `LPC_ADDR_STAT, 32'h4);
    $display("test reset done");
    bus(1, `LPC_ADDR_TRIG, 32'h5);
    // Sweep reaches the discouraged low codes too, to cover every decode
    for (c = 0; c < 8; c++)
    begin
      v = {c[2:0], c[1:0], 3'b001};
      bus(1, `LPC_ADDR_CTRL, {24'h0, v & 8'hFE});
      bus(0, `LPC_ADDR_STAT, 32'h4);
      bus(1, `LPC_ADDR_CTRL, {24'h0, v});
      span(0, n);
      chk("sleep", n, (1 << c) + 1);
      span(1, n);
      chk("settle", n, (1 << c[1:0]) + 1);
      span(2, n);
      chk("resleep", slp, 1'b1);
    end
    $display("test auto done");
    bus(1, `LPC_ADDR_CTRL, 32'hEA);
    bus(1, `LPC_ADDR_CTRL, 32'hEB);
    bus(1, `LPC_ADDR_TRIG, 32'h7);
    repeat (150 + $urandom_range(50, 0)) @(posedge clk_in);
    chk("hold", slp, 1'b1);
    bus(1, `LPC_ADDR_TRIG, 32'h6);
    bus(0, `LPC_ADDR_STAT, 32'h5);
    repeat (20) @(posedge clk_in);
    chk("pin hold", slp, 1'b1);
    wake <= 1'b1;
    span(1, n);
    chk("pin settle", n, 3);
    @(posedge clk_in);
    wake <= 1'b0;
    span(2, n);
    chk("pin resleep", slp, 1'b1);
    bus(1, `LPC_ADDR_TRIG, 32'h5);
    bus(1, `LPC_ADDR_TRIG, 32'h4);
    span(1, n);
    chk("soft settle", n, 3);
    $display("test trigger done");
    rstn_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'b1;
    bus(0, `LPC_ADDR_CTRL, 32'h88);
    bus(0, `LPC_ADDR_STAT, 32'h4);
    $display("test rearm done");
    results();
  end
endmodule : lowpower_bg_cal_scheduler_test

`default_nettype wire
